// ---- rtl/pixel_port_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the pixel port
`ifndef PIXEL_PORT_CFG_SVH
`define PIXEL_PORT_CFG_SVH

`define PP_CLK_PERIOD_NS   100
`define PP_PIXELS_PER_LOAD 8
`define PP_PIXEL_BITS      24
`define PP_INDEX_BITS      3

`define PP_OFF_CTRL        12'h000
`define PP_OFF_STATUS      12'h004
`define PP_OFF_IRQ_STATUS  12'h008
`define PP_OFF_IRQ_MASK    12'h00C

`define PP_CTRL_BLANK_INV  0
`define PP_CTRL_SYNC_INV   1
`define PP_CTRL_SYNC_BLUE  2
`define PP_CTRL_SYNC_GREEN 3
`define PP_CTRL_SYNC_RED   4
`define PP_CTRL_SYNC_OUT   5
`define PP_CTRL_RELEASE    6
`define PP_CTRL_WIDTH      7
`define PP_CTRL_RESET      7'h00

`define PP_EV_MONITOR      0
`define PP_EV_VSYNC        1
`define PP_EV_LOAD         2
`define PP_EV_WIDTH        3
`define PP_EV_RESET        3'h0

`endif

// ---- rtl/pixel_port_pkg.sv ----
// Types shared by the pixel port files
package pixel_port_pkg;
	// One channel as handed to its converter
	typedef struct packed {
		logic [7:0] code;
		logic       blank;
		logic       sync;
	} channel_drive_t;

	// Controls captured with each load
	typedef struct packed {
		logic hsync;
		logic vsync;
		logic composite_sync_in;
		logic blank;
	} pixel_ctrl_t;

	// Drive for the complementary outputs
	typedef struct packed {
		logic blank;
		logic sync;
	} inverted_drive_t;
endpackage

// ---- rtl/pixel_store.sv ----
// Eight-entry pixel store written a whole load at a time, registered read
`timescale 1ns/100ps
module pixel_store #(
	parameter int PIXELS = 8,
	parameter int WIDTH  = 24,
	parameter int ABITS  = 3
) (
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	input  wire logic                    write_all,
	input  wire logic [PIXELS*WIDTH-1:0] word_in,
	input  wire logic [ABITS-1:0]        read_index,
	output logic      [WIDTH-1:0]        read_data
);
	logic [WIDTH-1:0] mem [PIXELS];

	// Whole word lands in one cycle
	genvar g;
	generate
		for (g = 0; g < PIXELS; g++) begin : g_slot
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					mem[g] <= '0;
				end else if (write_all) begin
					mem[g] <= word_in[g*WIDTH +: WIDTH];
				end
			end
		end
	endgenerate

	// Read port registered so the converter sees a clean word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			read_data <= '0;
		end else begin
			read_data <= mem[read_index];
		end
	end
endmodule

// ---- rtl/pixel_port.sv ----
// Pixel port: load capture, 8:1 serialiser, sync/blank encoding, sense pin
//
// What this block does
// - 192-bit word holds eight 24-bit pixels
// - Capture colour on load input rising edge
// - Load output is pixel clock over eight
// - Syncs and blank captured with colour
// - Blank forces blanking, sync forces sync level
// - Per-channel enable puts sync on channel
// - All three channel enables low: no sync on any channel
// - Two enables put blank/sync on inverted
// - Sense high when any output above threshold
// - Sense aligned to presented pixel
// - Sense pin may carry delayed sync
// - Pixels split into three 8-bit converters
// - Enables map blue, green, red
// - Select bit swaps sense for pipelined sync
// - Release rising edge restarts pixel sequence
// - With release set, load output rises three clocks after load input
`timescale 1ns/100ps
`include "pixel_port_cfg.svh"
module pixel_port #(
	parameter int PIXELS = `PP_PIXELS_PER_LOAD,
	parameter int WIDTH  = `PP_PIXEL_BITS
) (
	input  wire logic                         hclk,
	input  wire logic                         hresetn,
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic      [31:0]                  hrdata,
	output logic                              hreadyout,
	output logic                              hresp,
	output logic                              irq,
	input  wire logic                         pixel_load_clock_in,
	input  wire logic [PIXELS*WIDTH-1:0]      pixel_word_in,
	input  wire pixel_port_pkg::pixel_ctrl_t  pixel_ctrl_in,
	input  wire logic [2:0]                   comparator_above,
	output logic                              pixel_load_clock_out,
	output pixel_port_pkg::channel_drive_t    red_current_out,
	output pixel_port_pkg::channel_drive_t    green_current_out,
	output pixel_port_pkg::channel_drive_t    blue_current_out,
	output pixel_port_pkg::inverted_drive_t   inverted_drive,
	output logic                              monitor_detect_or_sync_out
);
	import pixel_port_pkg::*;

	localparam int IB = `PP_INDEX_BITS;

	logic [`PP_CTRL_WIDTH-1:0] ctrl;
	logic [`PP_EV_WIDTH-1:0]   irq_status;
	logic [`PP_EV_WIDTH-1:0]   irq_mask;
	logic                      rd_pending;
	logic                      wr_pending;
	logic [11:0]               wr_addr;
	logic                      load_s1, load_s2, load_s3;
	logic [PIXELS*WIDTH-1:0]   word_s1, word_s2;
	pixel_ctrl_t               pctl_s1, pctl_s2, pctl_held, pctl_pipe;
	logic [2:0]                cmp_s1, cmp_s2;
	logic                      load_rise;
	logic                      release_q;
	logic                      restart;
	logic [IB-1:0]             pix_idx;
	logic [WIDTH-1:0]          pixel_now;
	logic                      monitor_absent;
	logic                      monitor_q;
	logic                      vsync_q;
	logic [`PP_EV_WIDTH-1:0]   events;

	// Register index decode, used by read only; writes compare wr_addr directly
	function automatic logic [1:0] reg_sel(input logic [11:0] a);
		case (a)
			`PP_OFF_CTRL:       reg_sel = 2'h0;
			`PP_OFF_STATUS:     reg_sel = 2'h1;
			`PP_OFF_IRQ_STATUS: reg_sel = 2'h2;
			default:            reg_sel = 2'h3;
		endcase
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == `PP_OFF_CTRL) || (a == `PP_OFF_STATUS) ||
			(a == `PP_OFF_IRQ_STATUS) || (a == `PP_OFF_IRQ_MASK);
	endfunction

	// Zero-wait slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Address phase capture; read data registered here
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_pending <= 1'b0;
			wr_pending <= 1'b0;
			wr_addr    <= 12'h000;
			hrdata     <= 32'h00000000;
		end else begin
			rd_pending <= 1'b0;
			wr_pending <= 1'b0;
			if (hsel && htrans[1] && hready) begin
				wr_pending <= hwrite;
				rd_pending <= !hwrite;
				wr_addr    <= haddr[11:0];
				hrdata     <= 32'h00000000;
				if (!hwrite && is_mapped(haddr[11:0])) begin
					case (reg_sel(haddr[11:0]))
						2'h0:    hrdata <= {25'h0, ctrl};
						2'h1:    hrdata <= {28'h0000000, pctl_held.hsync,
							pctl_held.vsync, pix_idx == 3'h0, monitor_absent};
						2'h2:    hrdata <= {29'h0, irq_status};
						default: hrdata <= {29'h0, irq_mask};
					endcase
				end
			end
		end
	end

	// Control and mask written in data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl     <= `PP_CTRL_RESET;
			irq_mask <= `PP_EV_RESET;
		end else if (wr_pending) begin
			if (wr_addr == `PP_OFF_CTRL) begin
				ctrl <= hwdata[`PP_CTRL_WIDTH-1:0];
			end
			if (wr_addr == `PP_OFF_IRQ_MASK) begin
				irq_mask <= hwdata[`PP_EV_WIDTH-1:0];
			end
		end
	end

	// Sticky events, read clears, a new event wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status <= `PP_EV_RESET;
		end else begin
			if (hsel && htrans[1] && hready && !hwrite &&
				haddr[11:0] == `PP_OFF_IRQ_STATUS) begin
				irq_status <= events;
			end else begin
				irq_status <= irq_status | events;
			end
		end
	end

	assign irq = |(irq_status & irq_mask);

	// Pins cross two flops before any logic looks at them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			load_s1 <= 1'b0;
			load_s2 <= 1'b0;
			load_s3 <= 1'b0;
			word_s1 <= '0;
			word_s2 <= '0;
			pctl_s1 <= '0;
			pctl_s2 <= '0;
			cmp_s1  <= 3'h0;
			cmp_s2  <= 3'h0;
		end else begin
			load_s1 <= pixel_load_clock_in;
			load_s2 <= load_s1;
			load_s3 <= load_s2;
			word_s1 <= pixel_word_in;
			word_s2 <= word_s1;
			pctl_s1 <= pixel_ctrl_in;
			pctl_s2 <= pctl_s1;
			cmp_s1  <= comparator_above;
			cmp_s2  <= cmp_s1;
		end
	end

	assign load_rise = load_s2 && !load_s3;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pctl_held <= '0;
		end else if (load_rise) begin
			pctl_held <= pctl_s2;
		end
	end

	// release edge restarts; realign on load edge while release is set
	assign restart = (ctrl[`PP_CTRL_RELEASE] && !release_q) ||
		(ctrl[`PP_CTRL_RELEASE] && load_rise);

	// one pixel per clock, first first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			release_q <= 1'b0;
			pix_idx   <= 3'h0;
		end else begin
			release_q <= ctrl[`PP_CTRL_RELEASE];
			if (restart) begin
				pix_idx <= 3'h0;
			end else begin
				pix_idx <= pix_idx + 3'h1;
			end
		end
	end

	// divide by eight, high for first half
	assign pixel_load_clock_out = !pix_idx[2];

	// whole wide word stored per load
	pixel_store #(
		.PIXELS (PIXELS),
		.WIDTH  (WIDTH),
		.ABITS  (IB)
	) u_store (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.write_all  (load_rise),
		.word_in    (word_s2),
		.read_index (pix_idx),
		.read_data  (pixel_now)
	);

	// Controls delayed to match the store's read register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pctl_pipe <= '0;
		end else begin
			pctl_pipe <= pctl_held;
		end
	end

	// split into three 8-bit channels; blank zeroes code
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			red_current_out   <= '0;
			green_current_out <= '0;
			blue_current_out  <= '0;
			inverted_drive    <= '0;
		end else begin
			red_current_out.code   <= pctl_pipe.blank ? 8'h00 : pixel_now[23:16];
			green_current_out.code <= pctl_pipe.blank ? 8'h00 : pixel_now[15:8];
			blue_current_out.code  <= pctl_pipe.blank ? 8'h00 : pixel_now[7:0];
			red_current_out.blank   <= pctl_pipe.blank;
			green_current_out.blank <= pctl_pipe.blank;
			blue_current_out.blank  <= pctl_pipe.blank;
			blue_current_out.sync  <= pctl_pipe.composite_sync_in && ctrl[`PP_CTRL_SYNC_BLUE];
			green_current_out.sync <= pctl_pipe.composite_sync_in && ctrl[`PP_CTRL_SYNC_GREEN];
			red_current_out.sync   <= pctl_pipe.composite_sync_in && ctrl[`PP_CTRL_SYNC_RED];
			inverted_drive.blank <= pctl_pipe.blank && ctrl[`PP_CTRL_BLANK_INV];
			inverted_drive.sync  <= pctl_pipe.composite_sync_in && ctrl[`PP_CTRL_SYNC_INV];
		end
	end

	assign monitor_absent = |cmp_s2;

	// sense or pipelined sync, registered with pixel
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			monitor_detect_or_sync_out <= 1'b0;
		end else if (ctrl[`PP_CTRL_SYNC_OUT]) begin
			monitor_detect_or_sync_out <= pctl_pipe.composite_sync_in;
		end else begin
			monitor_detect_or_sync_out <= monitor_absent;
		end
	end

	// Event edges for the interrupt register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			monitor_q <= 1'b0;
			vsync_q   <= 1'b0;
		end else begin
			monitor_q <= monitor_absent;
			vsync_q   <= pctl_held.vsync;
		end
	end

	assign events = {load_rise, pctl_held.vsync && !vsync_q, monitor_absent && !monitor_q};

	property p_capture;
		@(posedge hclk) disable iff (!hresetn)
		load_rise |=> pctl_held == $past(pctl_s2);
	endproperty
	a_capture: assert property (p_capture) else $error("controls not captured");

	property p_divide;
		@(posedge hclk) disable iff (!hresetn)
		(pix_idx == 3'h3 && !restart) |=> $fell(pixel_load_clock_out);
	endproperty
	a_divide: assert property (p_divide) else $error("load out not divided by 8");

	property p_blank;
		@(posedge hclk) disable iff (!hresetn)
		pctl_pipe.blank |=> red_current_out.code == 8'h00 && blue_current_out.blank;
	endproperty
	a_blank: assert property (p_blank) else $error("blank not forced");

	property p_no_sync;
		@(posedge hclk) disable iff (!hresetn)
		ctrl[4:2] == 3'h0 |=> !red_current_out.sync && !green_current_out.sync &&
			!blue_current_out.sync;
	endproperty
	a_no_sync: assert property (p_no_sync) else $error("sync leaked");

	property p_sense;
		@(posedge hclk) disable iff (!hresetn)
		(!ctrl[`PP_CTRL_SYNC_OUT] && cmp_s2 != 3'h0) |=> monitor_detect_or_sync_out;
	endproperty
	a_sense: assert property (p_sense) else $error("sense missing");

	property p_sync_out;
		@(posedge hclk) disable iff (!hresetn)
		ctrl[`PP_CTRL_SYNC_OUT] |=> monitor_detect_or_sync_out == $past(pctl_pipe.composite_sync_in);
	endproperty
	a_sync_out: assert property (p_sync_out) else $error("sync out wrong");

	property p_restart;
		@(posedge hclk) disable iff (!hresetn)
		$rose(ctrl[`PP_CTRL_RELEASE]) |=> pix_idx == 3'h0 ##1 (pix_idx == 3'h1 || $past(restart));
	endproperty
	a_restart: assert property (p_restart) else $error("sequence not restarted");

	property p_order;
		@(posedge hclk) disable iff (!hresetn)
		!restart |=> pix_idx == $past(pix_idx) + 3'h1;
	endproperty
	a_order: assert property (p_order) else $error("pixel order broken");
endmodule

// ---- verification/frame_feeder.sv ----
// Frame-buffer side model: load clock, pixel word and controls
`timescale 1ns/100ps
module frame_feeder (
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	input  wire logic [191:0]                word,
	input  wire pixel_port_pkg::pixel_ctrl_t ctrl,
	output logic                             pixel_load_clock_in,
	output logic [191:0]                     pixel_word_in,
	output pixel_port_pkg::pixel_ctrl_t      pixel_ctrl_in
);
	import pixel_port_pkg::*;
	logic [2:0] phase;

	// Load period of eight pixel clocks, high half first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= 3'h0;
			pixel_load_clock_in <= 1'b0;
		end else begin
			phase <= phase + 3'h1;
			pixel_load_clock_in <= (phase < 3'h4);
		end
	end

	// all eight pixels and controls together
	// Changed mid low half so they stand still around the rising edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pixel_word_in <= '0;
			pixel_ctrl_in <= '0;
		end else if (phase == 3'h6) begin
			pixel_word_in <= word;
			pixel_ctrl_in <= ctrl;
		end
	end
endmodule

// ---- verification/pixel_port_sync_blank_sense_bench.sv ----
// Self-checking bench for the pixel port
`timescale 1ns/100ps
module pixel_port_sync_blank_sense_bench;
	import pixel_port_pkg::*;
	logic            hclk, hresetn, hsel, hwrite, irq, hreadyout, hresp;
	logic            load_in, load_out, sense;
	logic [31:0]     haddr, hwdata, hrdata, q;
	logic [1:0]      htrans;
	logic [2:0]      hsize, cmp;
	logic [191:0]    word, pword;
	pixel_ctrl_t     ctrl, pctrl;
	channel_drive_t  red, green, blue;
	inverted_drive_t inv;
	int              miscompares, n_checks, i, k, highs;
	// Rows: control reg, captured controls, comparators, expected flags
	logic [20:0]     rows [10];

	pixel_port pixel_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.irq(irq), .pixel_load_clock_in(load_in), .pixel_word_in(pword),
		.pixel_ctrl_in(pctrl), .comparator_above(cmp), .pixel_load_clock_out(load_out),
		.red_current_out(red), .green_current_out(green), .blue_current_out(blue),
		.inverted_drive(inv), .monitor_detect_or_sync_out(sense));

	frame_feeder frame_feeder_inst (.hclk(hclk), .hresetn(hresetn), .word(word),
		.ctrl(ctrl), .pixel_load_clock_in(load_in), .pixel_word_in(pword),
		.pixel_ctrl_in(pctrl));

	task automatic results();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One single transfer; waits are bounded, never a fixed latency
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		q = hrdata;
		if (n >= 40) begin
			miscompares++;
			results();
		end
	endtask

	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	initial begin
		rows = '{{7'h40, 4'h2, 3'h0, 7'h00}, {7'h44, 4'h2, 3'h0, 7'h10},
			{7'h48, 4'h2, 3'h0, 7'h20}, {7'h50, 4'h2, 3'h0, 7'h40},
			{7'h43, 4'h3, 3'h0, 7'h0E}, {7'h41, 4'h3, 3'h0, 7'h0C},
			{7'h5C, 4'h0, 3'h0, 7'h00}, {7'h60, 4'h2, 3'h0, 7'h01},
			{7'h40, 4'h0, 3'h4, 7'h01}, {7'h60, 4'h0, 3'h4, 7'h00}};
		hresetn <= 1'b0;
		hsel <= 1'b0;
		haddr <= '0;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hsize <= 3'h2;
		hwdata <= '0;
		ctrl <= '0;
		cmp <= 3'h0;
		// Pixel k carries R=1k G=2k B=3k so order slips show
		word <= 192'h172737162636152535142434132333122232112131102030;
		repeat (3) @(posedge hclk);
		chk("reset outputs", 3'h6, {load_out, hreadyout, hresp});
		chk("reset idle", 14'h0, {irq, sense, red, inv});
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 12'h000, 32'h0);
		chk("ctrl reset", 32'h0, q);
		bus(1'b0, 12'h010, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("reset test done");
		// Each row settles over several load periods, then one look
		for (i = 0; i < 10; i++) begin
			bus(1'b1, 12'h000, {25'h0, rows[i][20:14]});
			ctrl <= rows[i][13:10];
			cmp <= rows[i][9:7];
			repeat (40) @(posedge hclk);
			@(negedge hclk);
			chk("flags", rows[i][6:0], {red.sync, green.sync, blue.sync, red.blank,
				inv.blank, inv.sync, sense});
			if (rows[i][3])
				chk("blank code", 24'h0, {red.code, green.code, blue.code});
			$display("row %0d done", i);
			@(posedge hclk);
		end
		ctrl <= '0;
		cmp <= 3'h0;
		repeat (24) @(posedge hclk);
		k = 0;
		do begin
			@(negedge hclk);
			k++;
		end while (load_out !== 1'b0 && k < 20);
		do begin
			@(negedge hclk);
			k++;
		end while (load_out !== 1'b1 && k < 40);
		if (k >= 40) begin
			miscompares++;
			results();
		end
		// Load out rises while the load input is still in its high half
		chk("load out phase", 1'b1, load_in);
		// Pixel zero reaches the converters two edges after index zero
		repeat (2) @(negedge hclk);
		highs = 0;
		for (i = 0; i < 8; i++) begin
			chk("pixel", word[24*i +: 24], {red.code, green.code, blue.code});
			highs += int'(load_out);
			@(negedge hclk);
		end
		chk("load out high", 32'h4, highs);
		$display("order test done");
		@(posedge hclk);
		bus(1'b1, 12'h00C, 32'h1);
		bus(1'b0, 12'h008, 32'h0);
		cmp <= 3'h1;
		repeat (10) @(posedge hclk);
		chk("irq set", 1'b1, irq);
		bus(1'b0, 12'h004, 32'h0);
		chk("status absent", 1'b1, q[0]);
		bus(1'b0, 12'h008, 32'h0);
		chk("irq cause", 1'b1, q[0]);
		@(negedge hclk);
		chk("irq cleared", 1'b0, irq);
		@(posedge hclk);
		bus(1'b1, 12'h00C, 32'h0);
		cmp <= 3'h0;
		repeat (10) @(posedge hclk);
		cmp <= 3'h2;
		repeat (10) @(posedge hclk);
		chk("irq masked", 1'b0, irq);
		$display("interrupt test done");
		// Frame syncs reach status and the vsync event bit
		ctrl <= 4'hC;
		repeat (30) @(posedge hclk);
		bus(1'b0, 12'h004, 32'h0);
		chk("status syncs", 2'h3, q[3:2]);
		bus(1'b0, 12'h008, 32'h0);
		chk("events seen", 3'h7, q[2:0]);
		$display("sync status test done");
		// Reset in mid-run must bring back the idle state
		hresetn <= 1'b0;
		@(posedge hclk);
		chk("mid reset", 4'hC, {load_out, hreadyout, hresp, irq});
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 12'h000, 32'h0);
		chk("ctrl after reset", 32'h0, q);
		$display("mid reset test done");
		results();
	end
endmodule
